// ---- hw/dqtr_pkg.sv ----
// Purpose: shared codes, addresses, defaults and timing counts of the DQ training link
// Assumes: both ends run on a 20 MHz ref_clk; the host makes the link clock
// Notes:   lane vectors are {dmi[1:0], dq[15:0]}
package dqtr_pkg;
  typedef enum logic [2:0] {
    CMD_DES    = 3'h0,
    CMD_MPC    = 3'h1,
    CMD_CAS2   = 3'h2,
    CMD_WRITE  = 3'h3,
    CMD_MWRITE = 3'h4,
    CMD_READ   = 3'h5,
    CMD_MRR    = 3'h6,
    CMD_MRW    = 3'h7
  } dqtr_cmd_t;

  typedef struct packed {
    logic       cke;
    logic [5:0] addr;
    logic [7:0] op;
    logic [2:0] code;
  } dqtr_cmdw_t;

  localparam int         LANES          = 18;
  localparam int         BEATS          = 16;
  localparam int         FIFO_DEPTH     = 5;
  localparam int         OP_VALID_BIT   = 6;
  localparam logic [5:0] OP_RD_FIFO     = 6'h01;
  localparam logic [5:0] OP_RD_CAL      = 6'h03;
  localparam logic [5:0] OP_WR_FIFO     = 6'h07;
  localparam logic [5:0] MR_DBI         = 6'h03;
  localparam logic [5:0] MR_DM          = 6'h0D;
  localparam logic [5:0] MR_INV0        = 6'h0F;
  localparam logic [5:0] MR_INV1        = 6'h14;
  localparam logic [5:0] MR_CAL_FIRST   = 6'h20;
  localparam logic [5:0] MR_CAL_SECOND  = 6'h28;
  localparam int         DM_DIS_POS     = 5;
  localparam int         WR_INV_POS     = 7;
  localparam int         RD_INV_POS     = 6;
  localparam logic [7:0] CAL_FIRST_RST  = 8'h5A;
  localparam logic [7:0] CAL_SECOND_RST = 8'h3C;
  localparam logic [7:0] INV_MASK_RST   = 8'h55;
  localparam logic       DM_DIS_RST     = 1'b1;
  localparam logic       INV_EN_RST     = 1'b0;
  localparam int         READ_LATENCY   = 6;
  localparam int         WRITE_LATENCY  = 4;
  localparam int         REF_MHZ        = 20;
  localparam int         LINK_PERIOD_NS = 400;
  localparam int         LINK_HALF_CYC  = LINK_PERIOD_NS * REF_MHZ / 2000;
  localparam int         CAL_PD_WAIT_NS = 18;
  localparam int         CAL_PD_WAIT_CYC = (CAL_PD_WAIT_NS * REF_MHZ + 999) / 1000;
  localparam logic [7:0] APB_CMD        = 8'h00;
  localparam logic [7:0] APB_CTRL       = 8'h04;
  localparam logic [7:0] APB_WDATA      = 8'h08;
  localparam logic [7:0] APB_STATUS     = 8'h0C;
  localparam logic [1:0] APB_RDBUF_PAGE = 2'h1;
endpackage

// ---- hw/dqtr_link_if.sv ----
// Purpose: pins between the training host and the memory device
// Assumes: undriven lanes and strobe read as low
// Notes:   device drive wins over host drive
`timescale 1ns/1ps
interface dqtr_link_if;
  logic        linkClk;
  logic        cke;
  logic [2:0]  cmdCode;
  logic [7:0]  cmdOp;
  logic [5:0]  cmdAddr;
  logic [17:0] hostLane;
  logic        hostLaneOe;
  logic        hostStb;
  logic        hostStbOe;
  logic [17:0] devLane;
  logic        devDqOe;
  logic        devDmiOe;
  logic        devStb;
  logic        devStbOe;
  logic [17:0] laneBus;
  logic        stbBus;

  assign laneBus[15:0]  = devDqOe ? devLane[15:0] : (hostLaneOe ? hostLane[15:0] : 16'h0000);
  assign laneBus[17:16] = devDmiOe ? devLane[17:16] : (hostLaneOe ? hostLane[17:16] : 2'h0);
  assign stbBus         = devStbOe ? devStb : (hostStbOe ? hostStb : 1'b0);

  modport host (output linkClk, cke, cmdCode, cmdOp, cmdAddr, hostLane, hostLaneOe, hostStb, hostStbOe,
                input laneBus, stbBus);
  modport dev  (input linkClk, cke, cmdCode, cmdOp, cmdAddr, laneBus, stbBus,
                output devLane, devDqOe, devDmiOe, devStb, devStbOe);
endinterface

// ---- hw/dqtr_device.sv ----
// Purpose: device end: read calibration pattern and five-entry training FIFO
// Assumes: host holds each command for two link rises and makes the link clock
// Notes:   link pins pass three flops; a change counts once stages two and three agree
//
// What this block does
// - Calibration drives first then second byte everywhere
// - Pattern bytes go out low bit first
// - Lanes with mask bit set are inverted
// - Mask/inversion lanes are never inverted
// - Mask/inversion lanes float only when all disabled
// - No bus inversion on calibration output
// - Host waits extra delay after power-down exit before read calibration
// - Operation valid bit low means no-op
// - Valid bit high selects training function
// - Host follows training command with column command
// - Column command operands all low
// - FIFO write latency from second column edge
// - Five sixteen-beat bursts stored per lane
// - FIFO read latency from second column edge
// - FIFO reads leave contents intact
// - Clock-enable low or read commands disturb FIFO
// - Unwritten entries return stale but legal data
// - Reads step entries zero to four, wrap
// - Data captured on incoming strobe edge
// - Pattern 5A/3C, masks 55 after reset
// - Mask bits map to lanes in order
// - Pointers reset on reset and power-down
// - Sixth write overwrites first entry
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module dqtr_device #(
  parameter int RL    = dqtr_pkg::READ_LATENCY,
  parameter int WL    = dqtr_pkg::WRITE_LATENCY,
  parameter int DEPTH = dqtr_pkg::FIFO_DEPTH
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  dqtr_link_if.dev        link,
  output      logic       trainBusy,
  output      logic [2:0] fifoWrPtr,
  output      logic [2:0] fifoRdPtr
);
  if (RL < 1 || RL > 63 || WL < 1 || WL > 63) begin : g_bad_latency
    $error("dqtr_device: latency out of range");
  end
  if (DEPTH < 2 || DEPTH > 8) begin : g_bad_depth
    $error("dqtr_device: depth out of range");
  end

  typedef enum logic [2:0] {
    DEV_IDLE   = 3'h0,
    DEV_RWAIT  = 3'h1,
    DEV_RBURST = 3'h2,
    DEV_WWAIT  = 3'h3,
    DEV_WBURST = 3'h4
  } dqtr_dev_fsm_t;

  typedef struct packed {
    logic [2:0]                    lkSync;
    logic                          lkLvl;
    logic [2:0]                    stbSync;
    logic                          stbLvl;
    dqtr_pkg::dqtr_cmdw_t [2:0]    cmdSync;
    dqtr_pkg::dqtr_cmdw_t          cmdWord;
    logic [2:0][17:0]              laneSync;
    logic [7:0]                    calFirst;
    logic [7:0]                    calSecond;
    logic [7:0]                    invMask0;
    logic [7:0]                    invMask1;
    logic                          dmDisable;
    logic                          wrInvEn;
    logic                          rdInvEn;
    logic                          phase;
    logic [2:0]                    heldCode;
    logic [7:0]                    heldOp;
    logic [5:0]                    heldAddr;
    logic                          mpcPend;
    logic [5:0]                    mpcSel;
    dqtr_dev_fsm_t                 state;
    logic [5:0]                    cnt;
    logic [3:0]                    beat;
    logic                          fromCal;
    logic [2:0]                    wrPtr;
    logic [2:0]                    rdPtr;
    logic [DEPTH-1:0][15:0][17:0]  mem;
    logic [17:0]                   laneOut;
    logic                          dqOe;
    logic                          dmiOe;
    logic                          stbOut;
    logic                          stbOe;
    logic                          busy;
  } dqtr_dev_s_t;

  localparam logic [2:0] PTR_LAST = 3'(DEPTH - 1);

  dqtr_dev_s_t r;
  dqtr_dev_s_t next_r;
  logic        lkRise;
  logic        lkFall;
  logic        stbRise;
  logic        driveNow;
  logic [3:0]  outBeat;
  logic        calBit;

  always_comb begin
    next_r   = r;
    driveNow = 1'b0;
    outBeat  = 4'h0;
    calBit   = 1'b0;
    next_r.lkSync   = {r.lkSync[1:0], link.linkClk};
    next_r.stbSync  = {r.stbSync[1:0], link.stbBus};
    next_r.cmdSync  = {r.cmdSync[1:0], link.cke, link.cmdAddr, link.cmdOp, link.cmdCode};
    next_r.laneSync = {r.laneSync[1:0], link.laneBus};
    if (r.lkSync[1] == r.lkSync[2]) begin
      next_r.lkLvl = r.lkSync[2];
    end
    if (r.stbSync[1] == r.stbSync[2]) begin
      next_r.stbLvl = r.stbSync[2];
    end
    if (r.cmdSync[1] == r.cmdSync[2]) begin
      next_r.cmdWord = r.cmdSync[2];
    end
    lkRise  = next_r.lkLvl & ~r.lkLvl;
    lkFall  = ~next_r.lkLvl & r.lkLvl;
    stbRise = next_r.stbLvl & ~r.stbLvl;

    if (!r.cmdWord.cke) begin
      next_r.state   = DEV_IDLE;
      next_r.wrPtr   = 3'h0;
      next_r.rdPtr   = 3'h0;
      next_r.phase   = 1'b0;
      next_r.mpcPend = 1'b0;
      next_r.dqOe    = 1'b0;
      next_r.dmiOe   = 1'b0;
      next_r.stbOe   = 1'b0;
    end else begin
      if (lkRise) begin
        case (r.state)
          DEV_RWAIT: begin
            if (r.cnt == 6'h01) begin
              next_r.state = DEV_RBURST;
              next_r.beat  = 4'h0;
              driveNow     = 1'b1;
              outBeat      = 4'h0;
            end else begin
              next_r.cnt = r.cnt - 6'h01;
            end
          end
          DEV_RBURST: begin
            if (r.beat == 4'hF) begin
              next_r.state = DEV_IDLE;
              next_r.dqOe  = 1'b0;
              next_r.dmiOe = 1'b0;
              next_r.stbOe = 1'b0;
              if (!r.fromCal) begin
                next_r.rdPtr = (r.rdPtr == PTR_LAST) ? 3'h0 : r.rdPtr + 3'h1;
              end
            end else begin
              next_r.beat = r.beat + 4'h1;
              driveNow    = 1'b1;
              outBeat     = r.beat + 4'h1;
            end
          end
          DEV_WWAIT: begin
            if (r.cnt == 6'h01) begin
              next_r.state = DEV_WBURST;
              next_r.beat  = 4'h0;
            end else begin
              next_r.cnt = r.cnt - 6'h01;
            end
          end
          default: begin
          end
        endcase

        if (r.cmdWord.code != dqtr_pkg::CMD_DES) begin
          if (!r.phase) begin
            next_r.phase    = 1'b1;
            next_r.heldCode = r.cmdWord.code;
            next_r.heldOp   = r.cmdWord.op;
            next_r.heldAddr = r.cmdWord.addr;
          end else begin
            next_r.phase   = 1'b0;
            next_r.mpcPend = 1'b0;
            case (dqtr_pkg::dqtr_cmd_t'(r.heldCode))
              dqtr_pkg::CMD_MPC: begin
                if (r.heldOp[dqtr_pkg::OP_VALID_BIT]) begin
                  if (r.heldOp[5:0] == dqtr_pkg::OP_RD_FIFO || r.heldOp[5:0] == dqtr_pkg::OP_RD_CAL ||
                      r.heldOp[5:0] == dqtr_pkg::OP_WR_FIFO) begin
                    next_r.mpcPend = 1'b1;
                    next_r.mpcSel  = r.heldOp[5:0];
                  end
                end
              end
              dqtr_pkg::CMD_CAS2: begin
                if (r.mpcPend && r.state == DEV_IDLE) begin
                  if (r.mpcSel == dqtr_pkg::OP_WR_FIFO) begin
                    next_r.state = DEV_WWAIT;
                    next_r.cnt   = 6'(WL);
                  end else begin
                    next_r.state   = DEV_RWAIT;
                    next_r.cnt     = 6'(RL);
                    next_r.fromCal = (r.mpcSel == dqtr_pkg::OP_RD_CAL);
                  end
                end
              end
              dqtr_pkg::CMD_READ: begin
                next_r.wrPtr = (r.wrPtr == PTR_LAST) ? 3'h0 : r.wrPtr + 3'h1;
                next_r.rdPtr = (r.rdPtr == PTR_LAST) ? 3'h0 : r.rdPtr + 3'h1;
              end
              dqtr_pkg::CMD_MRW: begin
                case (r.heldAddr)
                  dqtr_pkg::MR_CAL_FIRST:  next_r.calFirst  = r.heldOp;
                  dqtr_pkg::MR_CAL_SECOND: next_r.calSecond = r.heldOp;
                  dqtr_pkg::MR_INV0:       next_r.invMask0  = r.heldOp;
                  dqtr_pkg::MR_INV1:       next_r.invMask1  = r.heldOp;
                  dqtr_pkg::MR_DM:         next_r.dmDisable = r.heldOp[dqtr_pkg::DM_DIS_POS];
                  dqtr_pkg::MR_DBI: begin
                    next_r.wrInvEn = r.heldOp[dqtr_pkg::WR_INV_POS];
                    next_r.rdInvEn = r.heldOp[dqtr_pkg::RD_INV_POS];
                  end
                  default: begin
                  end
                endcase
              end
              default: begin
              end
            endcase
          end
        end
      end

      if (driveNow) begin
        calBit = outBeat[3] ? r.calSecond[outBeat[2:0]] : r.calFirst[outBeat[2:0]];
        next_r.dqOe   = 1'b1;
        next_r.dmiOe  = !(r.dmDisable && !r.wrInvEn && !r.rdInvEn);
        next_r.stbOe  = 1'b1;
        next_r.stbOut = 1'b0;
        if (r.fromCal) begin
          next_r.laneOut = {{2{calBit}}, {16{calBit}} ^ {r.invMask1, r.invMask0}};
        end else begin
          next_r.laneOut = r.mem[r.rdPtr][outBeat];
        end
      end
      if (lkFall && r.state == DEV_RBURST) begin
        next_r.stbOut = 1'b1;
      end
      if (stbRise && r.state == DEV_WBURST) begin
        next_r.mem[r.wrPtr][r.beat] = r.laneSync[2];
        if (r.beat == 4'hF) begin
          next_r.state = DEV_IDLE;
          next_r.wrPtr = (r.wrPtr == PTR_LAST) ? 3'h0 : r.wrPtr + 3'h1;
        end else begin
          next_r.beat = r.beat + 4'h1;
        end
      end
    end
    next_r.busy = (next_r.state != DEV_IDLE);
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r           <= '0;
      r.calFirst  <= dqtr_pkg::CAL_FIRST_RST;
      r.calSecond <= dqtr_pkg::CAL_SECOND_RST;
      r.invMask0  <= dqtr_pkg::INV_MASK_RST;
      r.invMask1  <= dqtr_pkg::INV_MASK_RST;
      r.dmDisable <= dqtr_pkg::DM_DIS_RST;
      r.wrInvEn   <= dqtr_pkg::INV_EN_RST;
      r.rdInvEn   <= dqtr_pkg::INV_EN_RST;
    end else begin
      r <= next_r;
    end
  end

  assign link.devLane  = r.laneOut;
  assign link.devDqOe  = r.dqOe;
  assign link.devDmiOe = r.dmiOe;
  assign link.devStb   = r.stbOut;
  assign link.devStbOe = r.stbOe;
  assign trainBusy     = r.busy;
  assign fifoWrPtr     = r.wrPtr;
  assign fifoRdPtr     = r.rdPtr;
endmodule // dqtr_device

// ---- hw/dqtr_host.sv ----
// Purpose: controller end: issues training commands ordered over APB
// Assumes: APB master per APB3; link clock made here by a divider
// Notes:   read bursts land in a sixteen-word buffer readable over APB
`timescale 1ns/1ps
module dqtr_host #(
  parameter int RL      = dqtr_pkg::READ_LATENCY,
  parameter int WL      = dqtr_pkg::WRITE_LATENCY,
  parameter int HALF    = dqtr_pkg::LINK_HALF_CYC,
  parameter int PD_WAIT = dqtr_pkg::CAL_PD_WAIT_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  dqtr_link_if.host        link
);
  if (WL < 1 || WL > 63 || RL < 1 || HALF < 2 || HALF > 255 || PD_WAIT < 1 || PD_WAIT > 65535) begin : g_bad
    $error("dqtr_host: parameter out of range");
  end

  typedef enum logic [2:0] {
    HST_IDLE   = 3'h0,
    HST_CMD    = 3'h1,
    HST_CAS    = 3'h2,
    HST_WWAIT  = 3'h3,
    HST_WBURST = 3'h4,
    HST_RCAP   = 3'h5
  } dqtr_host_fsm_t;

  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             cke;
    logic [17:0]      wdata;
    logic             reqPend;
    logic [2:0]       reqCode;
    logic [7:0]       reqOp;
    logic [5:0]       reqAddr;
    logic [7:0]       divCnt;
    logic             linkClk;
    dqtr_host_fsm_t   state;
    logic             half;
    logic [5:0]       cnt;
    logic [3:0]       beat;
    logic [15:0]      pdCnt;
    logic [2:0]       stbSync;
    logic             stbLvl;
    logic [2:0][17:0] laneSync;
    logic [15:0][17:0] rdBuf;
    logic [2:0]       cmdCode;
    logic [7:0]       cmdOp;
    logic [5:0]       cmdAddr;
    logic [17:0]      laneOut;
    logic             laneOe;
    logic             stbOut;
    logic             stbOe;
  } dqtr_host_s_t;

  dqtr_host_s_t r;
  dqtr_host_s_t next_r;
  logic         lkRise;
  logic         lkFall;
  logic         stbRise;
  logic         training;
  logic         calReady;

  always_comb begin
    next_r   = r;
    lkRise   = 1'b0;
    lkFall   = 1'b0;
    next_r.stbSync  = {r.stbSync[1:0], link.stbBus};
    next_r.laneSync = {r.laneSync[1:0], link.laneBus};
    if (r.stbSync[1] == r.stbSync[2]) begin
      next_r.stbLvl = r.stbSync[2];
    end
    stbRise = next_r.stbLvl & ~r.stbLvl;
    if (r.divCnt == 8'(HALF - 1)) begin
      next_r.divCnt  = 8'h00;
      next_r.linkClk = ~r.linkClk;
      lkRise         = ~r.linkClk;
      lkFall         = r.linkClk;
    end else begin
      next_r.divCnt = r.divCnt + 8'h01;
    end
    if (!r.cke) begin
      next_r.pdCnt = 16'h0000;
    end else if (r.pdCnt != 16'(PD_WAIT)) begin
      next_r.pdCnt = r.pdCnt + 16'h0001;
    end
    calReady = (r.pdCnt == 16'(PD_WAIT));
    training = (r.reqCode == dqtr_pkg::CMD_MPC) && r.reqOp[dqtr_pkg::OP_VALID_BIT] &&
               (r.reqOp[5:0] == dqtr_pkg::OP_RD_FIFO || r.reqOp[5:0] == dqtr_pkg::OP_RD_CAL ||
                r.reqOp[5:0] == dqtr_pkg::OP_WR_FIFO);

    next_r.pready = psel && penable && !r.pready;
    if (psel && penable && !r.pready) begin
      next_r.pslverr = 1'b0;
      next_r.prdata  = 32'h0000_0000;
      if (paddr[7:6] == dqtr_pkg::APB_RDBUF_PAGE && paddr[1:0] == 2'h0) begin
        next_r.prdata = {14'h0000, r.rdBuf[paddr[5:2]]};
      end else begin
        case (paddr)
          dqtr_pkg::APB_CMD:    next_r.prdata = {r.reqOp, 6'h00, r.reqAddr, 9'h000, r.reqCode};
          dqtr_pkg::APB_CTRL:   next_r.prdata = {31'h0000_0000, r.cke};
          dqtr_pkg::APB_WDATA:  next_r.prdata = {14'h0000, r.wdata};
          dqtr_pkg::APB_STATUS: next_r.prdata = {30'h0000_0000, calReady, r.reqPend || r.state != HST_IDLE};
          default:              next_r.pslverr = 1'b1;
        endcase
      end
    end
    if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        dqtr_pkg::APB_CMD: begin
          if (!r.reqPend && r.state == HST_IDLE) begin
            next_r.reqPend = 1'b1;
            next_r.reqCode = pwdata[2:0];
            next_r.reqOp   = pwdata[31:24];
            next_r.reqAddr = pwdata[17:12];
          end
        end
        dqtr_pkg::APB_CTRL:  next_r.cke   = pwdata[0];
        dqtr_pkg::APB_WDATA: next_r.wdata = pwdata[17:0];
        default: begin
        end
      endcase
    end

    case (r.state)
      HST_IDLE: begin
        if (lkFall && r.reqPend && r.cke && (!training || r.reqOp[5:0] != dqtr_pkg::OP_RD_CAL || calReady)) begin
          next_r.reqPend = 1'b0;
          next_r.cmdCode = r.reqCode;
          next_r.cmdOp   = r.reqOp;
          next_r.cmdAddr = r.reqAddr;
          next_r.state   = HST_CMD;
          next_r.half    = 1'b0;
        end
      end
      HST_CMD: begin
        if (lkFall) begin
          next_r.half = 1'b1;
          if (r.half) begin
            next_r.half    = 1'b0;
            next_r.cmdCode = training ? dqtr_pkg::CMD_CAS2 : dqtr_pkg::CMD_DES;
            next_r.cmdOp   = 8'h00;
            next_r.cmdAddr = 6'h00;
            next_r.state   = training ? HST_CAS : HST_IDLE;
          end
        end
      end
      HST_CAS: begin
        if (lkFall) begin
          next_r.half = 1'b1;
          if (r.half) begin
            next_r.cmdCode = dqtr_pkg::CMD_DES;
            next_r.beat    = 4'h0;
            next_r.cnt     = 6'(WL);
            next_r.state   = (r.reqOp[5:0] == dqtr_pkg::OP_WR_FIFO) ? HST_WWAIT : HST_RCAP;
          end
        end
      end
      HST_WWAIT: begin
        if (lkRise) begin
          if (r.cnt == 6'h01) begin
            next_r.state   = HST_WBURST;
            next_r.laneOut = r.wdata;
            next_r.laneOe  = 1'b1;
            next_r.stbOut  = 1'b0;
            next_r.stbOe   = 1'b1;
          end else begin
            next_r.cnt = r.cnt - 6'h01;
          end
        end
      end
      HST_WBURST: begin
        if (lkFall) begin
          next_r.stbOut = 1'b1;
        end
        if (lkRise) begin
          next_r.stbOut = 1'b0;
          if (r.beat == 4'hF) begin
            next_r.state  = HST_IDLE;
            next_r.laneOe = 1'b0;
            next_r.stbOe  = 1'b0;
          end else begin
            next_r.beat    = r.beat + 4'h1;
            next_r.laneOut = r.wdata ^ {18{~r.beat[0]}};
          end
        end
      end
      HST_RCAP: begin
        if (stbRise) begin
          next_r.rdBuf[r.beat] = r.laneSync[2];
          next_r.beat          = r.beat + 4'h1;
          if (r.beat == 4'hF) begin
            next_r.state = HST_IDLE;
          end
        end
      end
      default: next_r.state = HST_IDLE;
    endcase
    if (!r.cke && r.state != HST_IDLE) begin
      next_r.state   = HST_IDLE;
      next_r.cmdCode = dqtr_pkg::CMD_DES;
      next_r.laneOe  = 1'b0;
      next_r.stbOe   = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign prdata          = r.prdata;
  assign pready          = r.pready;
  assign pslverr         = r.pslverr;
  assign link.linkClk    = r.linkClk;
  assign link.cke        = r.cke;
  assign link.cmdCode    = r.cmdCode;
  assign link.cmdOp      = r.cmdOp;
  assign link.cmdAddr    = r.cmdAddr;
  assign link.hostLane   = r.laneOut;
  assign link.hostLaneOe = r.laneOe;
  assign link.hostStb    = r.stbOut;
  assign link.hostStbOe  = r.stbOe;
endmodule // dqtr_host

// ---- testbench/dqtr_link_checker.sv ----
// Purpose: link checks between host and device
// Assumes: HALF matches the host divider
// Notes:   inputs mirror the link signals
`timescale 1ns/1ps
module dqtr_link_checker #(
  parameter int HALF = 2
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       linkClk,
  input wire logic       cke,
  input wire logic [2:0] cmdCode,
  input wire logic [7:0] cmdOp,
  input wire logic       hostLaneOe,
  input wire logic       devDqOe,
  input wire logic       devDmiOe,
  input wire logic       devStb,
  input wire logic       devStbOe
);
  localparam int LO = 32 * HALF - 1;
  localparam int HI = 32 * HALF + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [9:0] cyc;
  logic [4:0] rises;
  logic       stbQ;
  // Burst length and strobe count
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cyc   <= 10'h000;
      rises <= 5'h00;
      stbQ  <= 1'b0;
    end else begin
      cyc   <= devDqOe ? cyc + 10'h001 : 10'h000;
      rises <= devStbOe ? rises + {4'h0, devStb & ~stbQ} : 5'h00;
      stbQ  <= devStb;
    end
  end
  a_cas_follows: assert property ($changed(cmdCode) && $past(cmdCode) == 3'h1 && $past(cmdOp[6])
    |-> cmdCode == 3'h2) else $error("training command not followed by column command");
  a_cas_ops_low: assert property (cmdCode == 3'h2 |-> cmdOp == 8'h00)
    else $error("column command operands not low");
  a_cmd_on_fall: assert property ($changed(cmdCode) |-> !linkClk)
    else $error("command changed outside link low phase");
  a_dmi_with_dq: assert property (devDmiOe |-> devDqOe) else $error("mask lanes driven alone");
  a_no_contention: assert property (!(devDqOe && hostLaneOe)) else $error("both ends drive lanes");
  a_burst_len: assert property ($fell(devDqOe) |-> cyc inside {[LO:HI]})
    else $error("burst length wrong");
  a_burst_beats: assert property ($fell(devStbOe) |-> rises == 5'h10) else $error("strobe count wrong");
  a_cke_quiet: assert property (!cke [*7] |-> !devDqOe && !devStbOe)
    else $error("device drives with clock enable low");
endmodule // dqtr_link_checker

// ---- testbench/dram_dq_training_logic_tb.sv ----
// Purpose: bench for the training link, both ends
// Assumes: shortened link HALF=2, WL=2, default RL
// Notes:   calibration rows first, FIFO cases after
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module dram_dq_training_logic_tb;
  logic        ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h00000000, prdata, rd;
  logic        pready, pslverr, err, devBusy;
  logic [2:0]  wrPtr, rdPtr;
  int          num_errors = 0, checks_done = 0, tmo = 0;
  logic [47:0] rows [5] = '{48'h5A3C55550020, 48'h1C5955550020, 48'h2700FF004020,
                            48'hFF810FF08000, 48'h00FFAA330000};
  logic [5:0]  ma [6] = '{6'h20, 6'h28, 6'h0F, 6'h14, 6'h03, 6'h0D};
  dqtr_link_if link();
  dqtr_host #(.WL(2), .HALF(2), .PD_WAIT(1)) i_dqtr_host (.ref_clk, .reset_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link(link));
  dqtr_device #(.WL(2)) i_dqtr_device (.ref_clk, .reset_n, .link(link), .trainBusy(devBusy),
    .fifoWrPtr(wrPtr), .fifoRdPtr(rdPtr));
  dqtr_link_checker #(.HALF(2)) i_dqtr_link_checker (.ref_clk, .reset_n, .linkClk(link.linkClk),
    .cke(link.cke), .cmdCode(link.cmdCode), .cmdOp(link.cmdOp), .hostLaneOe(link.hostLaneOe),
    .devDqOe(link.devDqOe), .devDmiOe(link.devDmiOe), .devStb(link.devStb), .devStbOe(link.devStbOe));
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    tmo++;
    if (tmo == 30000) begin
      num_errors++;
      close_out();
    end
  end
  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [5:0] a, input logic [7:0] op);
    apb(1'b1, 8'h00, {op, 6'h00, a, 9'h000, c});
    do apb(1'b0, 8'h0C, 32'h0); while (rd[0] !== 1'b0);
    repeat (8) @(posedge ref_clk);
  endtask
  function automatic logic [17:0] cal(input logic [47:0] w, input int b);
    logic bt;
    logic dmiOn;
    bt = b < 8 ? w[40 + b] : w[32 + b - 8];
    dmiOn = !(w[5] && !w[15] && !w[14]);
    return {{2{bt & dmiOn}}, {8{bt}} ^ w[23:16], {8{bt}} ^ w[31:24]};
  endfunction
  initial begin
    logic [31:0] v;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    apb(1'b1, 8'h04, 32'h1);
    apb(1'b1, 8'h30, 32'h5);
    `CHK(err, 1'b1)
    for (int r = 0; r < 5; r++) begin
      for (int j = 0; j < 6 && r > 0; j++) cmd(3'h7, ma[j], rows[r][47 - 8 * j -: 8]);
      cmd(3'h1, 6'h00, 8'h43);
      for (int b = 0; b < 16; b++) begin
        apb(1'b0, 8'h40 + 8'(4 * b), 32'h0);
        `CHK(rd[17:0], cal(rows[r], b))
      end
      $display("calibration row %0d done", r);
    end
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, 8'h08, 32'h12340 + k);
      cmd(3'h1, 6'h00, 8'h47);
    end
    `CHK(wrPtr, 3'h1)
    for (int k = 0; k < 6; k++) begin
      v = 32'h12340 + ((k % 5) == 0 ? 5 : k % 5);
      cmd(3'h1, 6'h00, 8'h41);
      apb(1'b0, 8'h40, 32'h0);
      `CHK(rd[17:0], v[17:0])
      apb(1'b0, 8'h44, 32'h0);
      `CHK(rd[17:0], ~v[17:0])
    end
    `CHK(rdPtr, 3'h1)
    `CHK(devBusy, 1'b0)
    $display("fifo test done");
    apb(1'b1, 8'h04, 32'h0);
    repeat (3) apb(1'b0, 8'h0C, 32'h0);
    `CHK(wrPtr, 3'h0)
    `CHK(rdPtr, 3'h0)
    $display("power-down test done");
    close_out();
  end
endmodule // dram_dq_training_logic_tb
